/* File: hw/dfg_pkg.sv */
package dfg_pkg;

  // register map on the plain software port (word index)
  localparam logic [3:0] DFG_ADDR_FLAG = 4'h0;
  localparam logic [3:0] DFG_ADDR_GPIO_A = 4'h1;
  localparam logic [3:0] DFG_ADDR_GPIO_B = 4'h2;
  localparam logic [3:0] DFG_ADDR_STATUS = 4'h3;

  // flag register fields: one bit per subsystem
  localparam int DFG_FLAG_A_BIT = 0;
  localparam int DFG_FLAG_B_BIT = 1;
  // gpio register fields: data in [1:0], pin_direction_bits in [9:8]
  localparam int DFG_GPIO_DATA_LSB = 0;
  localparam int DFG_GPIO_DIR_LSB = 8;
  localparam int DFG_NUM_PINS = 2;
  // status register fields
  localparam int DFG_STAT_ROM_A_BIT = 0;
  localparam int DFG_STAT_ROM_B_BIT = 1;
  localparam int DFG_STAT_MEM_MODE_BIT = 2;

  // reset values
  localparam logic [1:0] DFG_FLAG_RST = 2'h0;
  localparam logic [1:0] DFG_DATA_RST = 2'h0;
  localparam logic [1:0] DFG_DIR_RST = 2'h0;
  localparam logic [15:0] DFG_RDATA_RST = 16'h0000;

  // strap capture sequencer
  typedef enum logic [1:0] {
    DFG_ST_RESET = 2'b00,
    DFG_ST_SAMPLE = 2'b01,
    DFG_ST_RUN = 2'b10
  } dfg_state_t;

  // per-subsystem pin group: input, output, output enable
  typedef struct packed {
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
  } dfg_pins_t;

endpackage

/* File: hw/dfg_sub_port.sv */
`timescale 1ns/1ps
// one subsystem's two general-purpose pins: data latch and direction bits
module dfg_sub_port
  import dfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] pin_in_i,
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_o,
  output logic [15:0] rd_word_o
);

  logic [1:0] data_q;
  logic [1:0] dir_q;

  // software write latches values and directions
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q <= DFG_DATA_RST;
      dir_q <= DFG_DIR_RST;
    end else if (wr_en_i) begin
      data_q <= wdata_i[DFG_GPIO_DATA_LSB +: DFG_NUM_PINS];
      dir_q <= wdata_i[DFG_GPIO_DIR_LSB +: DFG_NUM_PINS];
    end
  end

  // per-pin drive: output when direction bit is one
  genvar g;
  generate
    for (g = 0; g < DFG_NUM_PINS; g++) begin : g_pin
      assign pin_out_o[g] = data_q[g];
      assign pin_oe_o[g] = dir_q[g];
    end
  endgenerate

  // read back shows pin level, which follows the latch on output pins anyway
  always_comb begin
    rd_word_o = 16'h0000;
    rd_word_o[DFG_GPIO_DATA_LSB +: DFG_NUM_PINS] = pin_in_i;
    rd_word_o[DFG_GPIO_DIR_LSB +: DFG_NUM_PINS] = dir_q;
  end

endmodule // dfg_sub_port

/* File: hw/dfg_top.sv */
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
//Behaviour
// - per-subsystem flag output latch, bit-writable
// - flags float while output-off input low
// - gpio write latches and drives output pins
// - gpio read returns present pin levels
// - per-pin direction bit selects input/output
// - memory mode: pin0 strap sets rom enable
module dfg_top
  import dfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic out_off_n_i,
  input wire logic port_mode_select_i,
  output logic sub_a_flag_out_o,
  output logic sub_a_flag_out_oe_o,
  output logic sub_b_flag_out_o,
  output logic sub_b_flag_out_oe_o,
  input wire logic [1:0] sub_a_gen_pin_i,
  output logic [1:0] sub_a_gen_pin_o,
  output logic [1:0] sub_a_gen_pin_oe_o,
  input wire logic [1:0] sub_b_gen_pin_i,
  output logic [1:0] sub_b_gen_pin_o,
  output logic [1:0] sub_b_gen_pin_oe_o,
  output logic sub_a_rom_en_o,
  output logic sub_b_rom_en_o,
  output logic ext_memory_port_mode_o
);

  logic [1:0] flag_q;
  logic [15:0] rdata_q;
  logic rom_a_q;
  logic rom_b_q;
  logic mem_mode_q;
  dfg_state_t state_q;
  dfg_pins_t pins_a;
  dfg_pins_t pins_b;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic wr_a;
  logic wr_b;

  // address decode used by both write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  assign wr_a = wr_i && hit(addr_i, DFG_ADDR_GPIO_A);
  assign wr_b = wr_i && hit(addr_i, DFG_ADDR_GPIO_B);

  // flag latch: each bit written alone, bit enable in [3:2] selects which
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= DFG_FLAG_RST;
    end else if (wr_i && hit(addr_i, DFG_ADDR_FLAG)) begin
      if (wdata_i[DFG_FLAG_A_BIT + 2]) begin
        flag_q[DFG_FLAG_A_BIT] <= wdata_i[DFG_FLAG_A_BIT];
      end
      if (wdata_i[DFG_FLAG_B_BIT + 2]) begin
        flag_q[DFG_FLAG_B_BIT] <= wdata_i[DFG_FLAG_B_BIT];
      end
    end
  end

  // output-off forces both flag pins to float; latch keeps its value
  assign sub_a_flag_out_o = flag_q[DFG_FLAG_A_BIT];
  assign sub_b_flag_out_o = flag_q[DFG_FLAG_B_BIT];
  assign sub_a_flag_out_oe_o = out_off_n_i;
  assign sub_b_flag_out_oe_o = out_off_n_i;

  assign pins_a.pin_in = sub_a_gen_pin_i;
  assign pins_b.pin_in = sub_b_gen_pin_i;

  dfg_sub_port u_port_a (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_a),
    .wdata_i(wdata_i),
    .pin_in_i(pins_a.pin_in),
    .pin_out_o(pins_a.pin_out),
    .pin_oe_o(pins_a.pin_oe),
    .rd_word_o(word_a)
  );

  dfg_sub_port u_port_b (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_b),
    .wdata_i(wdata_i),
    .pin_in_i(pins_b.pin_in),
    .pin_out_o(pins_b.pin_out),
    .pin_oe_o(pins_b.pin_oe),
    .rd_word_o(word_b)
  );

  assign sub_a_gen_pin_o = pins_a.pin_out;
  assign sub_a_gen_pin_oe_o = pins_a.pin_oe;
  assign sub_b_gen_pin_o = pins_b.pin_out;
  assign sub_b_gen_pin_oe_o = pins_b.pin_oe;

  // strap capture: one cycle after release, pins are inputs so straps are clean
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= DFG_ST_RESET;
    end else begin
      unique case (state_q)
        DFG_ST_RESET: state_q <= DFG_ST_SAMPLE;
        DFG_ST_SAMPLE: state_q <= DFG_ST_RUN;
        DFG_ST_RUN: state_q <= DFG_ST_RUN;
        default: state_q <= DFG_ST_RESET;
      endcase
    end
  end

  // strap only counts in memory-port mode; host-port mode leaves rom off
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_a_q <= 1'b0;
      rom_b_q <= 1'b0;
      mem_mode_q <= 1'b0;
    end else if (state_q == DFG_ST_SAMPLE) begin
      mem_mode_q <= port_mode_select_i;
      rom_a_q <= port_mode_select_i && sub_a_gen_pin_i[0];
      rom_b_q <= port_mode_select_i && sub_b_gen_pin_i[0];
    end
  end

  assign sub_a_rom_en_o = rom_a_q;
  assign sub_b_rom_en_o = rom_b_q;
  assign ext_memory_port_mode_o = mem_mode_q;

  // read data registered, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= DFG_RDATA_RST;
    end else if (rd_i) begin
      rdata_q <= 16'h0000;
      if (hit(addr_i, DFG_ADDR_FLAG)) begin
        rdata_q[1:0] <= flag_q;
      end else if (hit(addr_i, DFG_ADDR_GPIO_A)) begin
        rdata_q <= word_a;
      end else if (hit(addr_i, DFG_ADDR_GPIO_B)) begin
        rdata_q <= word_b;
      end else if (hit(addr_i, DFG_ADDR_STATUS)) begin
        rdata_q[DFG_STAT_ROM_A_BIT] <= rom_a_q;
        rdata_q[DFG_STAT_ROM_B_BIT] <= rom_b_q;
        rdata_q[DFG_STAT_MEM_MODE_BIT] <= mem_mode_q;
      end
    end else begin
      rdata_q <= DFG_RDATA_RST;
    end
  end

  assign rdata_o = rdata_q;

  property p_flag_float;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !out_off_n_i |-> !sub_a_flag_out_oe_o && !sub_b_flag_out_oe_o;
  endproperty
  a_flag_float: assert property (p_flag_float) else $error("flag driven while off low");

  property p_flag_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_i && hit(addr_i, DFG_ADDR_FLAG) && wdata_i[2] |=> sub_a_flag_out_o == $past(wdata_i[0]);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag a not latched");

  property p_gpio_drive;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_a |=> sub_a_gen_pin_o == $past(wdata_i[1:0]) && sub_a_gen_pin_oe_o == $past(wdata_i[9:8]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio a write not applied");

  property p_dir_b;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_b |=> sub_b_gen_pin_oe_o == $past(wdata_i[9:8]);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("gpio b direction wrong");

  property p_gpio_read;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_i && hit(addr_i, DFG_ADDR_GPIO_B) |=> rdata_o[1:0] == $past(sub_b_gen_pin_i);
  endproperty
  a_gpio_read: assert property (p_gpio_read) else $error("gpio read not pin level");

  sequence s_sample;
    state_q == DFG_ST_SAMPLE;
  endsequence
  property p_rom_strap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_sample ##0 !port_mode_select_i |=> !sub_a_rom_en_o && !sub_b_rom_en_o;
  endproperty
  a_rom_strap: assert property (p_rom_strap) else $error("rom enabled in host mode");

  property p_rom_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      state_q == DFG_ST_RUN |=> $stable(sub_a_rom_en_o) && $stable(sub_b_rom_en_o);
  endproperty
  a_rom_hold: assert property (p_rom_hold) else $error("rom enable changed after capture");

  property p_inputs_after_reset;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      state_q != DFG_ST_RUN |-> sub_a_gen_pin_oe_o == 2'h0 || $past(wr_a);
  endproperty
  a_inputs_after_reset: assert property (p_inputs_after_reset) else $error("pin driven after reset");

  // flag b, whose write enable is clear, must keep its level
  property p_flag_keep;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_i && hit(addr_i, DFG_ADDR_FLAG) && !wdata_i[DFG_FLAG_B_BIT + 2] |=> $stable(sub_b_flag_out_o);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag b changed without enable");

  // read data stands one cycle only, so an idle bus shows zero
  property p_rdata_idle;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !rd_i |=> rdata_o == DFG_RDATA_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

  // memory-port mode with pin0 high must switch rom a on
  sequence s_strap_a_high;
    port_mode_select_i && sub_a_gen_pin_i[0];
  endsequence
  property p_rom_strap_on;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_sample ##0 s_strap_a_high |=> sub_a_rom_en_o;
  endproperty
  a_rom_strap_on: assert property (p_rom_strap_on) else $error("rom a not enabled by strap");

endmodule // dfg_top

/* File: verification/dfg_board.sv */
`timescale 1ns/1ps
// board circuitry on one subsystem's two general-purpose pins
module dfg_board
  import dfg_pkg::*;
(
  input wire logic [1:0] pin_out_i,
  input wire logic [1:0] pin_oe_i,
  input wire logic [1:0] drive_i,
  input wire logic mode_i,
  output logic [1:0] pin_lvl_o,
  output logic port_mode_select_o
);
  // board only drives a pin the device has released, so no contention
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      pin_lvl_o[k] = pin_oe_i[k] ? pin_out_i[k] : drive_i[k];
    end
  end
  // mode strap held steady by the board
  assign port_mode_select_o = mode_i;
endmodule // dfg_board

/* File: verification/test_dfg_top.sv */
`timescale 1ns/1ps
module test_dfg_top;
  import dfg_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [3:0] obs; logic [15:0] rd;} dfg_row_t;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, off_n = 1'b1, mode = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, rd_v;
  logic fa, fa_oe, fb, fb_oe, rom_a, rom_b, mem_mode, psel_a;
  logic [1:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, drv_a = 2'h3, drv_b = 2'h2;
  logic [3:0] obs;
  int num_errors = 0, check_count = 0;
  // writes then read-back: flag enables, gpio directions, unmapped address last
  dfg_row_t rows [9] = '{
    '{4'h0, 16'h000d, 4'h1, 16'h0001}, '{4'h0, 16'h0002, 4'h1, 16'h0001},
    '{4'h0, 16'h000a, 4'h3, 16'h0003}, '{4'h0, 16'h0004, 4'h2, 16'h0002},
    '{4'h1, 16'h0301, 4'hd, 16'h0301}, '{4'h1, 16'h0100, 4'h4, 16'h0102},
    '{4'h2, 16'h0203, 4'hb, 16'h0202}, '{4'h2, 16'h0000, 4'h0, 16'h0002},
    '{4'h5, 16'hffff, 4'h2, 16'h0000}};

  always #4 sys_clk_i = ~sys_clk_i;

  dfg_top u_dfg_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .out_off_n_i(off_n), .port_mode_select_i(psel_a),
    .sub_a_flag_out_o(fa), .sub_a_flag_out_oe_o(fa_oe), .sub_b_flag_out_o(fb), .sub_b_flag_out_oe_o(fb_oe),
    .sub_a_gen_pin_i(pa_i), .sub_a_gen_pin_o(pa_o), .sub_a_gen_pin_oe_o(pa_oe),
    .sub_b_gen_pin_i(pb_i), .sub_b_gen_pin_o(pb_o), .sub_b_gen_pin_oe_o(pb_oe),
    .sub_a_rom_en_o(rom_a), .sub_b_rom_en_o(rom_b), .ext_memory_port_mode_o(mem_mode));
  dfg_board u_dfg_board_a (.pin_out_i(pa_o), .pin_oe_i(pa_oe), .drive_i(drv_a), .mode_i(mode),
    .pin_lvl_o(pa_i), .port_mode_select_o(psel_a));
  dfg_board u_dfg_board_b (.pin_out_i(pb_o), .pin_oe_i(pb_oe), .drive_i(drv_b), .mode_i(mode),
    .pin_lvl_o(pb_i), .port_mode_select_o());

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle strobes; called just after an edge so back-to-back has no gap
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog: bounded, a run that overstays counts as a mismatch
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("pin oe after reset", 16'({pa_oe, pb_oe}), 16'h0000);
    check("strap capture", 16'({mem_mode, rom_b, rom_a}), 16'h0005);
    bus_rd(DFG_ADDR_STATUS, rd_v);
    check("status read", rd_v, 16'h0005);
    @(posedge sys_clk_i);
    #1;
    check("read data after its cycle", rdata_o, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      bus_wr(rows[i].a, rows[i].d);
      bus_rd(rows[i].a, rd_v);
      case (rows[i].a)
        4'h1: obs = {pa_oe, pa_o};
        4'h2: obs = {pb_oe, pb_o};
        default: obs = {2'h0, fb, fa};
      endcase
      check("port outputs", 16'(obs), 16'(rows[i].obs));
      check("read back", rd_v, rows[i].rd);
    end
    $display("test table done");
    // flags float only while the output-off input is low
    @(posedge sys_clk_i);
    off_n <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check("flag oe off", 16'({fb_oe, fa_oe}), 16'h0000);
    check("flag held", 16'({fb, fa}), 16'h0002);
    off_n <= 1'b1;
    #1;
    check("flag oe on", 16'({fb_oe, fa_oe}), 16'h0003);
    $display("test output off done");
    // second reset in host mode: pins released, rom stays off
    @(posedge sys_clk_i);
    mode <= 1'b0;
    rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check("outputs in reset", 16'({pa_o, pa_oe, pb_o, pb_oe, fb, fa}), 16'h0000);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("host mode strap", 16'({mem_mode, rom_b, rom_a}), 16'h0000);
    $display("test second reset done");
    test_done();
  end
endmodule // test_dfg_top
